// File: logic/pa_params.svh
// offsets, field positions, reset values and counts for the port a pin control block
`ifndef PA_PARAMS_SVH
`define PA_PARAMS_SVH

// byte offsets on the register bus, one aligned word each
`define PA_OFF_PINS     5'h00
`define PA_OFF_LATCH    5'h04
`define PA_OFF_DIR      5'h08
`define PA_OFF_ANA      5'h0C
`define PA_OFF_CMP      5'h10
`define PA_OFF_CVR      5'h14
`define PA_OFF_OSC      5'h18

// reset values
`define PA_RST_LATCH    8'h00
`define PA_RST_DIR      8'hFF
`define PA_RST_ANA      8'h00
`define PA_RST_CMP      8'h07
`define PA_RST_CVR      8'h00

// analog pin config fields
`define PA_ANA_REFSEL_HI 5
`define PA_ANA_REFSEL_LO 4
`define PA_ANA_MAP_MSB  3
`define PA_ANA_WMASK    8'h3F
`define PA_ANA_DIG_LIM  4'h7

// comparator control fields
`define PA_CMP_RES2     7
`define PA_CMP_RES1     6
`define PA_CMP_C2INV    5
`define PA_CMP_C1INV    4
`define PA_CMP_MODE_MSB 2
`define PA_CMP_WMASK    8'h3F
`define PA_CMP_OFF      3'h7
`define PA_CMP_ROUTE    3'h3

// comparator reference control fields
`define PA_CVR_EN       7
`define PA_CVR_OE       6

// cycle clock divider: output is the top bit of this counter
`define PA_CYCLE_CLOCK_OUTPUT_CNT_W   2

`endif

// File: logic/pa_pkg.sv
// types shared by the port a pin control block
package pa_pkg;

  typedef enum logic [3:0]
  {
    PA_OSC_LP      = 4'h0,
    PA_OSC_XT      = 4'h1,
    PA_OSC_HS      = 4'h2,
    PA_OSC_RC      = 4'h3,
    PA_OSC_RC_IO      = 4'h4,
    PA_OSC_INT_CLKOUT = 4'h5,
    PA_OSC_INT_IO     = 4'h6,
    PA_OSC_EC         = 4'h7,
    PA_OSC_EC_IO      = 4'h8
  } pa_osc_mode_type;

  // avalon-mm request from the master
  typedef struct packed
  {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pa_avreq_type;

  // drive of the eight pins
  typedef struct packed
  {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pa_pindrv_type;

endpackage

// File: logic/pa_port.sv
// port a pin control: eight-bit gpio port with analog, comparator and oscillator overrides
//
// What this block does
// - direction 0 drives the pin from the latch; analog selection leaves output alone
// - direction 1 samples the pin digitally, except while its analog function is on
// - after reset pins 0 to 3 and pin 5 sit in analog-input configuration
// - after reset pin 4 is a digital input
// - comparator one routed and direction 0 puts its result on pin 4
// - comparator two routed and direction 0 puts its result on pin 5
// - reference output on pin 2 disables its digital output and input
// - pin 6 is digital only in rc-io, internal-io and external-clock-io modes
// - rc, internal-clkout and external-clock modes drive cycle clock on pin 6
// - external oscillator modes disable the digital paths of pin 7
// - pins 6 and 7 read 0 in port, latch and direction when not i/o
// - oscillator, clock out and reference pins ignore their direction bit
// - unimplemented register bits read 0, top two of analog config included
// - pin 5 as input feeds its level to the serial port slave select
// - port read returns pin levels, port write updates the latch
// - latch register reads and writes the latched value, not the pins
// - direction 1 turns the driver off, direction 0 drives the latch
// - pins in analog configuration read 0 through the port register
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pa_params.svh"

module pa_port
#(
  parameter pa_pkg::pa_osc_mode_type OSC_RST = pa_pkg::PA_OSC_INT_IO
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire pa_pkg::pa_avreq_type bus_req,
  output logic [31:0]               bus_readdata,
  output logic                      bus_waitrequest,
  input  wire logic [7:0]           pin_in,
  output pa_pkg::pa_pindrv_type     pin_drv,
  input  wire logic                 cmp1_result,
  input  wire logic                 cmp2_result,
  output logic [7:0]                analog_pin_mask,
  output logic                      timer_external_clock_in,
  output logic                      slave_select_n
);
  import pa_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]      latch_ff;
  logic [7:0]      dir_ff;
  logic [7:0]      ana_cfg_ff;
  logic [7:0]      cmp_cfg_ff;
  logic [7:0]      cvr_ff;
  pa_osc_mode_type osc_ff;
  logic            ack_ff;
  logic [31:0]     readdata_ff;
  logic [7:0]      in_s1_ff;
  logic [7:0]      in_s2_ff;
  logic [7:0]      in_s3_ff;
  logic [7:0]      in_ff;
  logic [`PA_CYCLE_CLOCK_OUTPUT_CNT_W-1:0] clk_cnt_ff;
  pa_pindrv_type   drv_ff;
  logic [7:0]      ana_out_ff;
  logic            tmr_clk_ff;
  logic            ss_n_ff;

  logic            io6;
  logic            cyc_clk6;
  logic            io7;
  logic            cmp_on;
  logic            cmp_route;
  logic            c1_val;
  logic            c2_val;
  logic            refout;
  logic [3:0]      amap;
  logic [7:0]      ana_mask;
  logic [7:0]      dig_ok;
  logic [7:0]      io_mask;
  logic [7:0]      port_view;
  logic [7:0]      rd_byte;
  logic            wr_go;
  pa_pindrv_type   nxt_drv;

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser: a change counts once stages two and three agree

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      in_s1_ff <= 8'h00;
      in_s2_ff <= 8'h00;
      in_s3_ff <= 8'h00;
    end
    else
    begin
      in_s1_ff <= pin_in;
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
    end
  end

  // per-bit acceptance of a stable level
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      in_ff <= 8'h00;
    else
      in_ff <= (in_s2_ff & ~(in_s2_ff ^ in_s3_ff)) | (in_ff & (in_s2_ff ^ in_s3_ff));
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator mode decode

  // pin 6 and pin 7 roles per oscillator mode
  always_comb
  begin
    io6      = (osc_ff == PA_OSC_RC_IO) || (osc_ff == PA_OSC_INT_IO)
            || (osc_ff == PA_OSC_EC_IO);
    cyc_clk6 = (osc_ff == PA_OSC_RC) || (osc_ff == PA_OSC_INT_CLKOUT)
            || (osc_ff == PA_OSC_EC);
    io7      = (osc_ff == PA_OSC_INT_IO) || (osc_ff == PA_OSC_INT_CLKOUT);
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog, comparator and reference decode

  // comparator state, outputs with their inversion bits
  always_comb
  begin
    cmp_on    = cmp_cfg_ff[`PA_CMP_MODE_MSB:0] != `PA_CMP_OFF;
    cmp_route = cmp_cfg_ff[`PA_CMP_MODE_MSB:0] == `PA_CMP_ROUTE;
    c1_val    = cmp1_result ^ cmp_cfg_ff[`PA_CMP_C1INV];
    c2_val    = cmp2_result ^ cmp_cfg_ff[`PA_CMP_C2INV];
    refout    = cvr_ff[`PA_CVR_EN] & cvr_ff[`PA_CVR_OE];
    amap      = ana_cfg_ff[`PA_ANA_MAP_MSB:0];
  end

  // analog pins: channel k analog while the map value is below the limit less k
  always_comb
  begin
    ana_mask    = 8'h00;
    ana_mask[0] = (amap < `PA_ANA_DIG_LIM) | cmp_on;
    ana_mask[1] = (amap < (`PA_ANA_DIG_LIM - 4'h1)) | cmp_on;
    ana_mask[2] = (amap < (`PA_ANA_DIG_LIM - 4'h2)) | cmp_on
                | ana_cfg_ff[`PA_ANA_REFSEL_HI];
    ana_mask[3] = (amap < (`PA_ANA_DIG_LIM - 4'h3)) | cmp_on
                | ana_cfg_ff[`PA_ANA_REFSEL_LO];
    ana_mask[5] = amap < (`PA_ANA_DIG_LIM - 4'h4);
  end

  // pins with a digital path, and implemented register bits
  always_comb
  begin
    dig_ok    = 8'hFF;
    dig_ok[2] = ~refout;
    dig_ok[6] = io6;
    dig_ok[7] = io7;
    io_mask   = {io7, io6, 6'h3F};
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drive, one slice per pin

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      logic alt_en;
      logic alt_val;
      logic force_drv;
      assign alt_en    = ((gi == 4) | (gi == 5)) & cmp_route;
      assign alt_val   = (gi == 4) ? c1_val : c2_val;
      assign force_drv = (gi == 6) & cyc_clk6;
      // direction bit ignored for the clock output and disabled pins
      assign nxt_drv.oe_n[gi] = force_drv ? 1'b0 : (~dig_ok[gi] | dir_ff[gi]);
      assign nxt_drv.out[gi]  = force_drv ? clk_cnt_ff[`PA_CYCLE_CLOCK_OUTPUT_CNT_W-1]
                              : nxt_drv.oe_n[gi] ? 1'b0
                              : alt_en ? alt_val : latch_ff[gi];
      // input view: analog and disabled pins read 0
      assign port_view[gi] = dig_ok[gi] & ~ana_mask[gi] & in_ff[gi];
    end
  endgenerate

  // cycle clock divider, a quarter of the system clock
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      clk_cnt_ff <= '0;
    else
      clk_cnt_ff <= clk_cnt_ff + 1'b1;
  end

  // registered pin drive
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      drv_ff <= '{out: 8'h00, oe_n: 8'hFF};
    else
      drv_ff <= nxt_drv;
  end

  // registered peripheral outputs
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ana_out_ff <= 8'h00;
      tmr_clk_ff <= 1'b0;
      ss_n_ff    <= 1'b1;
    end
    else
    begin
      ana_out_ff <= ana_mask;
      tmr_clk_ff <= in_ff[4];
      ss_n_ff    <= dir_ff[5] ? in_ff[5] : 1'b1;
    end
  end

  assign pin_drv                 = drv_ff;
  assign analog_pin_mask         = ana_out_ff;
  assign timer_external_clock_in = tmr_clk_ff;
  assign slave_select_n          = ss_n_ff;

  //////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, then the answer

  assign bus_waitrequest = (bus_req.read | bus_req.write) & ~ack_ff;
  assign wr_go           = ack_ff & bus_req.write & bus_req.byteenable[0];
  assign bus_readdata    = readdata_ff;

  // answer flag
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ack_ff <= 1'b0;
    else
      ack_ff <= (bus_req.read | bus_req.write) & ~ack_ff;
  end

  // read mux, unmapped and unimplemented bits read 0
  always_comb
  begin
    case (bus_req.address)
      `PA_OFF_PINS:  rd_byte = port_view;
      `PA_OFF_LATCH: rd_byte = latch_ff & io_mask;
      `PA_OFF_DIR:   rd_byte = dir_ff & io_mask;
      `PA_OFF_ANA:   rd_byte = ana_cfg_ff & `PA_ANA_WMASK;
      `PA_OFF_CMP:   rd_byte = {c2_val, c1_val, cmp_cfg_ff[5:0]};
      `PA_OFF_CVR:   rd_byte = cvr_ff;
      `PA_OFF_OSC:   rd_byte = {4'h0, osc_ff};
      default:       rd_byte = 8'h00;
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      readdata_ff <= 32'h0000_0000;
    else if (bus_req.read & ~ack_ff)
      readdata_ff <= {24'h00_0000, rd_byte};
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  // output latch, written through either the port or the latch offset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      latch_ff <= `PA_RST_LATCH;
    else if (wr_go && ((bus_req.address == `PA_OFF_PINS)
                    || (bus_req.address == `PA_OFF_LATCH)))
      latch_ff <= bus_req.writedata[7:0];
  end

  // direction register, all inputs after reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      dir_ff <= `PA_RST_DIR;
    else if (wr_go && (bus_req.address == `PA_OFF_DIR))
      dir_ff <= bus_req.writedata[7:0];
  end

  // analog configuration, top two bits never stored
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ana_cfg_ff <= `PA_RST_ANA;
    else if (wr_go && (bus_req.address == `PA_OFF_ANA))
      ana_cfg_ff <= bus_req.writedata[7:0] & `PA_ANA_WMASK;
  end

  // comparator and reference control
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmp_cfg_ff <= `PA_RST_CMP;
      cvr_ff     <= `PA_RST_CVR;
    end
    else
    begin
      if (wr_go && (bus_req.address == `PA_OFF_CMP))
        cmp_cfg_ff <= bus_req.writedata[7:0] & `PA_CMP_WMASK;
      if (wr_go && (bus_req.address == `PA_OFF_CVR))
        cvr_ff <= bus_req.writedata[7:0];
    end
  end

  // oscillator mode selection
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      osc_ff <= OSC_RST;
    else if (wr_go && (bus_req.address == `PA_OFF_OSC))
      osc_ff <= pa_osc_mode_type'(bus_req.writedata[3:0]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_clk_rise;
    $rose(drv_ff.out[6]) && cyc_clk6 ##1 cyc_clk6 ##1 cyc_clk6;
  endsequence

  sequence s_latch_read;
    ack_ff && bus_req.read && (bus_req.address == `PA_OFF_LATCH) && !io7;
  endsequence

  property p_latch_drive;
    (dir_ff[0] == 1'b0) |=> (!drv_ff.oe_n[0] && (drv_ff.out[0] == $past(latch_ff[0])));
  endproperty
  a_latch_drive: assert property (p_latch_drive)
    else $error("pin 0 not driven from latch");

  property p_analog_reads_zero;
    bus_req.read && !ack_ff && (bus_req.address == `PA_OFF_PINS) && ana_mask[1]
      |=> !bus_readdata[1];
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero)
    else $error("analog pin 1 read nonzero");

  property p_reset_config;
    $fell(reset) |-> (ana_mask == 8'h2F) && dir_ff[4];
  endproperty
  a_reset_config: assert property (p_reset_config)
    else $error("wrong pin configuration after reset");

  property p_cmp1_drive;
    cmp_route && !dir_ff[4] |=> !drv_ff.oe_n[4] && (drv_ff.out[4] == $past(c1_val));
  endproperty
  a_cmp1_drive: assert property (p_cmp1_drive)
    else $error("pin 4 not carrying comparator one");

  property p_cmp2_drive;
    cmp_route && !dir_ff[5] |=> !drv_ff.oe_n[5] && (drv_ff.out[5] == $past(c2_val));
  endproperty
  a_cmp2_drive: assert property (p_cmp2_drive)
    else $error("pin 5 not carrying comparator two");

  property p_ref_off;
    refout |-> !port_view[2] ##1 drv_ff.oe_n[2];
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("pin 2 digital path active with reference out");

  property p_clk_out;
    s_clk_rise |-> !drv_ff.out[6] && !drv_ff.oe_n[6];
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("cycle clock on pin 6 wrong period");

  property p_pin7_off;
    !io7 |=> drv_ff.oe_n[7];
  endproperty
  a_pin7_off: assert property (p_pin7_off)
    else $error("pin 7 driven in external oscillator mode");

  property p_latch7_zero;
    s_latch_read |-> !bus_readdata[7];
  endproperty
  a_latch7_zero: assert property (p_latch7_zero)
    else $error("latch bit 7 read nonzero while not i/o");

  property p_dir_off;
    dir_ff[1] |=> drv_ff.oe_n[1] ##1 (drv_ff.oe_n[1] || !$past(dir_ff[1]));
  endproperty
  a_dir_off: assert property (p_dir_off)
    else $error("pin 1 driven while direction is input");

  property p_bus_answer;
    (bus_req.read || bus_req.write) && !ack_ff |=> !bus_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not after one wait cycle");

endmodule

// File: dv/pa_pins_model.sv
// partner model: package pins and comparator outputs around the port
`timescale 1ns/1ps

module pa_pins_model
#(
  parameter int CMP_LAG = 1
)
(
  input  wire logic                  clk_sys,
  input  wire pa_pkg::pa_pindrv_type pin_drv,
  input  wire logic [7:0]            ext_level,
  input  wire logic                  cmp1_level,
  input  wire logic                  cmp2_level,
  output logic [7:0]                 pin_in,
  output logic                       cmp1_result,
  output logic                       cmp2_result
);
  import pa_pkg::*;
  logic [3:0] c1_sh;
  logic [3:0] c2_sh;

  // a pin shows the port drive when enabled, else the outside level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = (pin_drv.oe_n[i] === 1'b0) ? pin_drv.out[i] : ext_level[i];
  end

  // comparators settle CMP_LAG clocks after their inputs move
  always_ff @(posedge clk_sys)
  begin
    c1_sh <= {c1_sh[2:0], cmp1_level};
    c2_sh <= {c2_sh[2:0], cmp2_level};
  end
  assign cmp1_result = c1_sh[CMP_LAG-1];
  assign cmp2_result = c2_sh[CMP_LAG-1];
endmodule

// File: dv/pa_port_tb.sv
// self-checking bench for the port a pin control block
`timescale 1ns/1ps
`include "pa_params.svh"

module pa_port_tb;
  import pa_pkg::*;
  logic          clk_sys = 1'b0;
  logic          reset = 1'b1;
  pa_avreq_type  bus_req = '0;
  logic [31:0]   bus_readdata;
  logic          bus_waitrequest;
  logic [7:0]    pin_in;
  pa_pindrv_type pin_drv;
  logic          cmp1_result;
  logic          cmp2_result;
  logic [7:0]    analog_pin_mask;
  logic          timer_external_clock_in;
  logic          slave_select_n;
  logic [7:0]    ext_level = 8'hFF;
  logic          cmp1_level = 1'b0;
  logic          cmp2_level = 1'b0;
  int            errors = 0;
  int            comparisons = 0;
  logic [31:0]   rd;
  logic [1:0]    io;
  int            highs;

  // 40 mhz system clock
  always #12.5 clk_sys = ~clk_sys;

  pa_port u_pa_port
  (
    .clk_sys                 (clk_sys),
    .reset                   (reset),
    .bus_req                 (bus_req),
    .bus_readdata            (bus_readdata),
    .bus_waitrequest         (bus_waitrequest),
    .pin_in                  (pin_in),
    .pin_drv                 (pin_drv),
    .cmp1_result             (cmp1_result),
    .cmp2_result             (cmp2_result),
    .analog_pin_mask         (analog_pin_mask),
    .timer_external_clock_in (timer_external_clock_in),
    .slave_select_n          (slave_select_n)
  );

  pa_pins_model u_pa_pins_model
  (
    .clk_sys     (clk_sys),
    .pin_drv     (pin_drv),
    .ext_level   (ext_level),
    .cmp1_level  (cmp1_level),
    .cmp2_level  (cmp2_level),
    .pin_in      (pin_in),
    .cmp1_result (cmp1_result),
    .cmp2_result (cmp2_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus tasks
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low at a falling edge, then through the next rising edge
  task automatic bus(input logic wr_en, input logic [4:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    bus_req.read <= ~wr_en;
    bus_req.write <= wr_en;
    bus_req.address <= addr;
    bus_req.writedata <= {24'h00_0000, data};
    bus_req.byteenable <= 4'hF;
    @(negedge clk_sys);
    while (bus_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        $display("wrong value at %0t: bus answer timed out", $time);
        tally_and_finish();
      end
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    rd = bus_readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] addr, input logic [7:0] data);
    bus(1'b1, addr, data);
  endtask

  task automatic rdc(input logic [4:0] addr, input logic [7:0] exp, input string what);
    bus(1'b0, addr, 8'h00);
    chk(rd, {24'h00_0000, exp}, what);
  endtask

  // let pin synchronisers and registered drives catch up
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    chk(pin_drv.oe_n, 8'hFF, "drivers off");
    chk(analog_pin_mask, 8'h2F, "analog map");
    chk(timer_external_clock_in, 1'b1, "pin 4 input");
    rdc(`PA_OFF_LATCH, 8'h00, "latch rst");
    rdc(`PA_OFF_DIR, 8'hFF, "dir rst");
    rdc(`PA_OFF_ANA, 8'h00, "ana rst");
    rdc(`PA_OFF_CMP, 8'h07, "cmp rst");
    rdc(`PA_OFF_CVR, 8'h00, "cvr rst");
    rdc(`PA_OFF_OSC, 8'h06, "osc rst");
    rdc(`PA_OFF_PINS, 8'hD0, "analog pins");
    wr(5'h1C, 8'h55);
    rdc(5'h1C, 8'h00, "unmapped");
    wr(`PA_OFF_ANA, 8'hFF);
    rdc(`PA_OFF_ANA, 8'h3F, "ana top");
    // digital inputs and slave select
    wr(`PA_OFF_ANA, 8'h0F);
    ext_level <= 8'hA5;
    settle();
    chk(analog_pin_mask, 8'h00, "all digital");
    rdc(`PA_OFF_PINS, 8'hA5, "pins");
    chk(slave_select_n, 1'b1, "select high");
    chk(timer_external_clock_in, 1'b0, "t clk low");
    ext_level <= 8'h5A;
    settle();
    chk(slave_select_n, 1'b0, "select low");
    chk(timer_external_clock_in, 1'b1, "t clk high");
    // outputs from the latch, pins read back
    wr(`PA_OFF_PINS, 8'h3C);
    wr(`PA_OFF_DIR, 8'hF0);
    settle();
    chk(pin_drv, 16'h0CF0, "low drive");
    rdc(`PA_OFF_PINS, 8'h5C, "mixed pins");
    rdc(`PA_OFF_LATCH, 8'h3C, "latch");
    wr(`PA_OFF_ANA, 8'h00);
    settle();
    chk(pin_drv, 16'h0CF0, "analog drive");
    rdc(`PA_OFF_PINS, 8'h50, "analog read");
    // comparator results routed to pins 4 and 5
    wr(`PA_OFF_ANA, 8'h0F);
    wr(`PA_OFF_DIR, 8'h00);
    wr(`PA_OFF_LATCH, 8'h00);
    wr(`PA_OFF_CMP, 8'h03);
    cmp1_level <= 1'b1;
    settle();
    chk(pin_drv.out[5:4], 2'b01, "cmp1 out");
    chk(analog_pin_mask, 8'h0F, "cmp analog");
    rdc(`PA_OFF_CMP, 8'h43, "cmp live");
    cmp1_level <= 1'b0;
    cmp2_level <= 1'b1;
    settle();
    chk(pin_drv.out[5:4], 2'b10, "cmp2 out");
    wr(`PA_OFF_CMP, 8'h07);
    // reference output on pin 2
    wr(`PA_OFF_LATCH, 8'h04);
    wr(`PA_OFF_CVR, 8'hC0);
    ext_level <= 8'hFF;
    settle();
    chk(pin_drv.oe_n[2], 1'b1, "ref drive off");
    wr(`PA_OFF_DIR, 8'hFF);
    settle();
    rdc(`PA_OFF_PINS, 8'hFB, "ref input off");
    wr(`PA_OFF_CVR, 8'h00);
    // every oscillator mode against pins 6 and 7
    wr(`PA_OFF_LATCH, 8'hC0);
    for (int m = 0; m < 9; m++)
    begin
      io = {(m == 5 || m == 6), (m == 4 || m == 6 || m == 8)};
      wr(`PA_OFF_OSC, m[7:0]);
      wr(`PA_OFF_DIR, 8'h3F);
      settle();
      chk(pin_drv.oe_n[7], !io[1], "pin 7 enable");
      if (m == 3 || m == 5 || m == 7)
      begin
        highs = 0;
        repeat (8)
        begin
          @(negedge clk_sys);
          highs += int'(pin_drv.out[6] === 1'b1);
        end
        chk(pin_drv.oe_n[6], 1'b0, "clock out enable");
        chk(highs, 4, "clock out duty");
      end
      else
        chk(pin_drv.oe_n[6], !io[0], "pin 6 enable");
      rdc(`PA_OFF_LATCH, {io, 6'h00}, "latch 7:6");
      wr(`PA_OFF_DIR, 8'hFF);
      rdc(`PA_OFF_DIR, {io, 6'h3F}, "dir 7:6");
      settle();
      rdc(`PA_OFF_PINS, {io, 6'h3F}, "pins 7:6");
    end
    tally_and_finish();
  end
endmodule
